// >>> charger_protection_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CPC_CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("Error t=%0t got %0h exp %0h", $time, (g), (e)); end end
module charger_protection_control_test;
  import cpc_pkg::*;
  logic              clk, rst, charge_enable, charge_start, power_limiter_disable, serial_factory_mode;
  logic              charger_fault_irq_mask, reverse_supply_enable, charge_mode_select, trickle_source_enable;
  logic              sm_trickle_request, charger_input_overvoltage, usb_overvoltage_comp, battery_min_comparator;
  logic              battery_turnon_comparator, accessory_over_slow, accessory_over_fast, charge_current_detect;
  logic              sm_battery_switch;
  logic              main_pass_on, battery_switch, charger_fault_irq, usb_disconnect, usb_overvoltage_irq;
  logic              accessory_path_on, accessory_short_irq, reverse_current_irq, trickle_source_on, trickle_level_80ma;
  logic [3:0]        programmed_current, applied_current, irq_vec, cur;
  logic [1:0]        power_budget_select, charger_fault_code;
  logic [15:0]       raw_mv, vbus_mv, bat_mv;
  logic signed [15:0] acc_ma;
  logic [13:0]       load_mw;
  logic [PWR_W-1:0]  pass_power_mw;
  logic [31:0]       m;
  logic [3:0]        irq_q[$];
  int                n_tests, n_mismatch, seed, cnt, bud;
  assign irq_vec = {charger_fault_irq, usb_overvoltage_irq, accessory_short_irq, reverse_current_irq};
  cpc_analog_model u_model (.clk, .raw_mv, .vbus_mv, .bat_mv, .acc_ma, .load_mw, .charger_input_overvoltage,
    .usb_overvoltage_comp, .battery_min_comparator, .battery_turnon_comparator, .accessory_over_slow,
    .accessory_over_fast, .charge_current_detect, .pass_power_mw);
  cpc_top #(.OV_RESUME_CYC(20), .CTRL_PERIOD_CYC(30), .BLANK_CYC(40), .SLOW_SHORT_CYC(10),
    .FAST_SHORT_CYC(3)) u_dut (.clk, .rst, .charger_input_overvoltage, .usb_overvoltage_comp, .charge_enable,
    .charge_start, .programmed_current, .pass_power_mw, .power_budget_select, .power_limiter_disable,
    .serial_factory_mode, .charger_fault_irq_mask, .reverse_supply_enable, .accessory_over_slow,
    .accessory_over_fast, .charge_current_detect, .battery_min_comparator, .battery_turnon_comparator,
    .charge_mode_select, .trickle_source_enable, .sm_trickle_request, .sm_battery_switch, .main_pass_on,
    .battery_switch, .applied_current, .charger_fault_code, .charger_fault_irq, .usb_disconnect,
    .usb_overvoltage_irq, .accessory_path_on, .accessory_short_irq, .reverse_current_irq, .trickle_source_on,
    .trickle_level_80ma);
  // ---------------------------------------------------------------
  // clock, interrupt monitor, watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (!rst && irq_vec !== 4'h0) begin
      if (irq_q.size() == 0) `CPC_CHK(irq_vec, 4'h0)
      else `CPC_CHK(irq_vec, irq_q.pop_front())
    end
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    $display("Error t=%0t run watchdog expired", $time);
    give_verdict();
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // sel 0 fault code, 1 battery switch, 2 accessory path
  task automatic wait_for(input int sel, input logic [1:0] val, input int lim);
    logic [1:0] v;
    for (int i = 0; i < lim; i++) begin
      @(posedge clk);
      v = (sel == 0) ? charger_fault_code : (sel == 1) ? {1'b0, battery_switch} : {1'b0, accessory_path_on};
      if (v === val) return;
    end
    n_mismatch++;
    $display("Error t=%0t wait %0d got %0h exp %0h", $time, sel, v, val);
    give_verdict();
  endtask
  task automatic rearm();
    acc_ma <= '0;
    reverse_supply_enable <= 1'b0;
    tick(3);
    reverse_supply_enable <= 1'b1;
    tick(3);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 27934;
    {rst, charge_enable, charge_start, power_limiter_disable, serial_factory_mode} = 5'h10;
    {charger_fault_irq_mask, reverse_supply_enable, charge_mode_select, trickle_source_enable} = 4'h0;
    {sm_battery_switch, sm_trickle_request, programmed_current, power_budget_select, load_mw, acc_ma} = '0;
    raw_mv = 16'd5000;
    vbus_mv = 16'd5000;
    bat_mv = 16'd3200;
    tick(6);
    rst <= 1'b0;
    tick(2);
    `CPC_CHK(charger_fault_code, FAULT_NONE)
    `CPC_CHK(main_pass_on, 1'b0)
    $display("test reset done");
    cur = 4'($random(seed)) | 4'h1;
    programmed_current <= cur;
    charge_enable <= 1'b1;
    tick(5);
    `CPC_CHK(applied_current, cur)
    raw_mv <= 16'd20000;
    tick(2);
    `CPC_CHK({main_pass_on, battery_switch}, 2'h1)
    tick(1);
    raw_mv <= 16'd5000;
    tick(25);
    irq_q.push_back(4'h8);
    raw_mv <= 16'd20000;
    wait_for(0, FAULT_SUPPLY, int'(OV_QUAL_CYC) + 8);
    `CPC_CHK(applied_current, 4'h0)
    tick(4);
    raw_mv <= 16'd5000;
    tick(12);
    `CPC_CHK(charger_fault_code, FAULT_SUPPLY)
    wait_for(0, FAULT_NONE, 20);
    `CPC_CHK(applied_current, cur)
    charger_fault_irq_mask <= 1'b1;
    raw_mv <= 16'd20000;
    wait_for(0, FAULT_SUPPLY, int'(OV_QUAL_CYC) + 8);
    raw_mv <= 16'd5000;
    wait_for(0, FAULT_NONE, 30);
    charger_fault_irq_mask <= 1'b0;
    irq_q.push_back(4'h4);
    vbus_mv <= 16'd7000;
    tick(4);
    `CPC_CHK(usb_disconnect, 1'b1)
    vbus_mv <= 16'd5000;
    tick(4);
    $display("test overvoltage done");
    for (int i = 0; i < 4; i++) begin
      bud = 600 + 200 * i;
      power_budget_select <= 2'(i);
      load_mw <= 14'(bud * 10);
      tick(6);
      `CPC_CHK(charger_fault_code, FAULT_NONE)
      irq_q.push_back(4'h8);
      load_mw <= 14'(bud * 10 + 1);
      wait_for(0, FAULT_SUPPLY, 6);
      tick(1);
      `CPC_CHK(main_pass_on, 1'b0)
      load_mw <= '0;
      tick(2);
      charge_start <= 1'b1;
      tick(1);
      charge_start <= 1'b0;
      wait_for(0, FAULT_NONE, 4);
    end
    tick(45);
    for (int k = 0; k < 3; k++) begin
      power_limiter_disable <= (k == 0);
      serial_factory_mode <= (k == 1);
      reverse_supply_enable <= (k == 2);
      load_mw <= 14'h3fff;
      tick(8);
      `CPC_CHK(charger_fault_code, FAULT_NONE)
      load_mw <= '0;
      tick(3);
      {power_limiter_disable, serial_factory_mode, reverse_supply_enable} <= 3'h0;
      tick(2);
    end
    power_budget_select <= 2'h0;
    load_mw <= 14'd700;
    wait_for(1, 2'h1, 40);
    cnt = 0;
    repeat (10) begin
      @(posedge clk);
      cnt += int'(main_pass_on === 1'b1);
    end
    `CPC_CHK(cnt, 9)
    load_mw <= 14'd100;
    wait_for(1, 2'h0, 200);
    charge_start <= 1'b1;
    load_mw <= 14'd700;
    tick(1);
    charge_start <= 1'b0;
    cnt = 0;
    repeat (38) begin
      @(posedge clk);
      cnt += int'(battery_switch !== 1'b0);
    end
    `CPC_CHK(cnt, 0)
    load_mw <= '0;
    wait_for(1, 2'h0, 200);
    charge_enable <= 1'b0;
    $display("test limiter done");
    rearm();
    `CPC_CHK(accessory_path_on, 1'b1)
    acc_ma <= 16'sd2000;
    tick(2);
    acc_ma <= '0;
    tick(4);
    `CPC_CHK(accessory_path_on, 1'b1)
    irq_q.push_back(4'h2);
    acc_ma <= 16'sd2000;
    wait_for(2, 2'h0, 10);
    rearm();
    irq_q.push_back(4'h2);
    acc_ma <= 16'sd600;
    wait_for(2, 2'h0, 20);
    rearm();
    irq_q.push_back(4'h1);
    acc_ma <= -16'sd100;
    wait_for(2, 2'h0, 5);
    acc_ma <= '0;
    reverse_supply_enable <= 1'b0;
    tick(4);
    $display("test reverse done");
    for (int i = 0; i < 8; i++) begin
      m = $random(seed);
      charge_mode_select <= i[0];
      trickle_source_enable <= m[1];
      sm_trickle_request <= m[2];
      sm_battery_switch <= m[4];
      bat_mv <= m[3] ? 16'd3200 : (i[1] ? 16'd3600 : 16'd2500);
      tick(4);
      `CPC_CHK(battery_switch, m[4])
      `CPC_CHK(trickle_source_on, (i[0] ? m[1] : m[2]))
      `CPC_CHK(trickle_level_80ma, m[3])
    end
    $display("test trickle done");
    `CPC_CHK(32'(irq_q.size()), 32'h0)
    give_verdict();
  end
endmodule
`default_nettype wire

// >>> cpc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpc_analog_model (
  input  wire logic                      clk,
  input  wire logic [15:0]               raw_mv,
  input  wire logic [15:0]               vbus_mv,
  input  wire logic [15:0]               bat_mv,
  input  wire logic signed [15:0]        acc_ma,
  input  wire logic [13:0]               load_mw,
  output logic                           charger_input_overvoltage,
  output logic                           usb_overvoltage_comp,
  output logic                           battery_min_comparator,
  output logic                           battery_turnon_comparator,
  output logic                           accessory_over_slow,
  output logic                           accessory_over_fast,
  output logic                           charge_current_detect,
  output logic [cpc_pkg::PWR_W-1:0]      pass_power_mw
);
  import cpc_pkg::*;

  localparam int RAW_OV_MV  = 18000;
  localparam int VBUS_OV_MV = 6000;
  localparam int BAT_MIN_MV = 3000;
  localparam int BAT_ON_MV  = 3400;
  localparam int SLOW_MA    = 500;
  localparam int FAST_MA    = 1840;
  localparam int REV_MA     = 35;
  // ---------------------------------------------------------------
  // comparators and power sensing, one cycle of filter delay
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    charger_input_overvoltage <= int'(raw_mv) > RAW_OV_MV;
    usb_overvoltage_comp      <= int'(vbus_mv) > VBUS_OV_MV;
    battery_min_comparator    <= int'(bat_mv) > BAT_MIN_MV;
    battery_turnon_comparator <= int'(bat_mv) > BAT_ON_MV;
    accessory_over_slow       <= int'(acc_ma) > SLOW_MA;
    accessory_over_fast       <= int'(acc_ma) > FAST_MA;
    charge_current_detect     <= int'(acc_ma) < -REV_MA;
    pass_power_mw             <= PWR_W'(load_mw);
  end
endmodule
`default_nettype wire

// >>> cpc_pkg.sv
// Function
// - input over-voltage opens both main pass devices and closes the battery switch at once
// - resume charging and restore programmed settings after 10 ms without over-voltage
// - over-voltage fault sets fault code 01 and raises the maskable charger fault interrupt
// - over-voltage pulses up to 30 us may skip the fault state and interrupt
// - usb supply over-voltage disconnects usb circuitry and raises its interrupt
// - over budget: duty cycle on main pass devices, updated each 500 ms, battery switch on
// - if 10 percent duty cannot hold budget, disable path, code 01, raise interrupt
// - budget code 00..11 selects 600, 800, 1000, 1200 mW, reset value 00
// - limiter disable input turns the dissipation limiter off; the code still faults beyond minimum duty during blanking
// - limiter is off in serial factory mode and in reverse supply mode; the code still faults beyond minimum duty during blanking
// - limiter output blanked for 1500 ms at the start of each charge cycle
// - during blanking keep estimating and disable charger below minimum duty cycle
// - reverse supply enable routes battery voltage to the accessory
// - reverse current over slow limit 1.0 ms or fast limit 100 us trips path and interrupt
// - current flowing back from accessory disables reverse path and raises interrupt
// - trickle current 40 mA below battery minimum, 80 mA between minimum and turn-on
// - software mode: trickle enable switches source on; standalone: state machine does
// - charge mode select 0 is standalone, 1 is software controlled
package cpc_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned OV_QUAL_US       = 30;
  localparam int unsigned OV_RESUME_MS     = 10;
  localparam int unsigned CTRL_PERIOD_MS   = 500;
  localparam int unsigned BLANK_MS         = 1500;
  localparam int unsigned SLOW_SHORT_US    = 1000;
  localparam int unsigned FAST_SHORT_US    = 100;
  localparam int unsigned OV_QUAL_CYC      = OV_QUAL_US * CLK_MHZ;
  localparam int unsigned OV_RESUME_CYC    = OV_RESUME_MS * 1000 * CLK_MHZ;
  localparam int unsigned CTRL_PERIOD_CYC  = CTRL_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int unsigned BLANK_CYC        = BLANK_MS * 1000 * CLK_MHZ;
  localparam int unsigned SLOW_SHORT_CYC   = SLOW_SHORT_US * CLK_MHZ;
  localparam int unsigned FAST_SHORT_CYC   = FAST_SHORT_US * CLK_MHZ;
  localparam int unsigned CNT_W            = 29;

  // ---------------------------------------------------------------
  // limiter
  // ---------------------------------------------------------------
  localparam int unsigned PWR_W            = 14;
  localparam logic [3:0]  DUTY_FULL        = 4'ha;
  localparam logic [3:0]  DUTY_MIN         = 4'h1;
  localparam logic [3:0]  MIN_DUTY_DIV     = 4'ha;
  localparam logic [1:0]  BUDGET_RESET     = 2'h0;
  localparam logic [PWR_W-1:0] BUDGET_600  = 14'h0258;
  localparam logic [PWR_W-1:0] BUDGET_800  = 14'h0320;
  localparam logic [PWR_W-1:0] BUDGET_1000 = 14'h03e8;
  localparam logic [PWR_W-1:0] BUDGET_1200 = 14'h04b0;

  // ---------------------------------------------------------------
  // codes and state
  // ---------------------------------------------------------------
  localparam logic [1:0]  FAULT_NONE       = 2'h0;
  localparam logic [1:0]  FAULT_SUPPLY     = 2'h1;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } cpc_tmr_s;

  typedef struct packed {
    logic             ov_fault;
    logic             pwr_fault;
    logic             blanking;
    logic [3:0]       duty;
    logic [3:0]       phase;
    logic             short_trip;
    logic             rev_trip;
    logic [1:0]       fault_code;
    logic             chg_irq;
    logic             usb_irq;
    logic             short_irq;
    logic             rev_irq;
    logic             usb_disc;
    logic             pass_on;
    logic             bat_sw;
    logic             acc_on;
    logic             trickle_on;
    logic             trickle_80;
    logic [3:0]       applied_current;
  } cpc_top_s;

  localparam cpc_top_s TOP_RESET = '{duty: DUTY_FULL, fault_code: FAULT_NONE, default: '0};

  function automatic logic [PWR_W-1:0] budget_mw(input logic [1:0] sel);
    unique case (sel)
      2'h0: budget_mw = BUDGET_600;
      2'h1: budget_mw = BUDGET_800;
      2'h2: budget_mw = BUDGET_1000;
      2'h3: budget_mw = BUDGET_1200;
    endcase
  endfunction

endpackage

// >>> cpc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module cpc_timer #(
  parameter int unsigned LIMIT = 2
) (
  input  wire logic clk,
  input  wire logic rst,
  cpc_tmr_if.tmr    t
);
  import cpc_pkg::*;

  cpc_tmr_s st;
  cpc_tmr_s next_st;

  // ---------------------------------------------------------------
  // counter, cleared whenever run drops, wraps on done
  // ---------------------------------------------------------------
  assign t.done = t.run && (st.cnt == CNT_W'(LIMIT - 1));

  always_comb begin
    next_st = st;
    if (!t.run || t.done) begin
      next_st.cnt = '0;
    end else begin
      next_st.cnt = st.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  a_run_clears: assert property (@(posedge clk) disable iff (rst)
    !t.run |=> st.cnt == '0) else $error("timer not cleared when idle");

endmodule
`default_nettype wire

// >>> cpc_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cpc_tmr_if;
  logic run;
  logic done;
  modport ctl (output run, input done);
  modport tmr (input run, output done);
endinterface
`default_nettype wire

// >>> cpc_top.sv
`timescale 1ns/1ps
`default_nettype none
module cpc_top #(
  parameter int unsigned OV_QUAL_CYC     = cpc_pkg::OV_QUAL_CYC,
  parameter int unsigned OV_RESUME_CYC   = cpc_pkg::OV_RESUME_CYC,
  parameter int unsigned CTRL_PERIOD_CYC = cpc_pkg::CTRL_PERIOD_CYC,
  parameter int unsigned BLANK_CYC       = cpc_pkg::BLANK_CYC,
  parameter int unsigned SLOW_SHORT_CYC  = cpc_pkg::SLOW_SHORT_CYC,
  parameter int unsigned FAST_SHORT_CYC  = cpc_pkg::FAST_SHORT_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      charger_input_overvoltage,
  input  wire logic                      usb_overvoltage_comp,
  input  wire logic                      charge_enable,
  input  wire logic                      charge_start,
  input  wire logic [3:0]                programmed_current,
  input  wire logic [cpc_pkg::PWR_W-1:0] pass_power_mw,
  input  wire logic [1:0]                power_budget_select,
  input  wire logic                      power_limiter_disable,
  input  wire logic                      serial_factory_mode,
  input  wire logic                      charger_fault_irq_mask,
  input  wire logic                      reverse_supply_enable,
  input  wire logic                      accessory_over_slow,
  input  wire logic                      accessory_over_fast,
  input  wire logic                      charge_current_detect,
  input  wire logic                      battery_min_comparator,
  input  wire logic                      battery_turnon_comparator,
  input  wire logic                      charge_mode_select,
  input  wire logic                      trickle_source_enable,
  input  wire logic                      sm_trickle_request,
  input  wire logic                      sm_battery_switch,
  output logic                           main_pass_on,
  output logic                           battery_switch,
  output logic [3:0]                     applied_current,
  output logic [1:0]                     charger_fault_code,
  output logic                           charger_fault_irq,
  output logic                           usb_disconnect,
  output logic                           usb_overvoltage_irq,
  output logic                           accessory_path_on,
  output logic                           accessory_short_irq,
  output logic                           reverse_current_irq,
  output logic                           trickle_source_on,
  output logic                           trickle_level_80ma
);
  import cpc_pkg::*;

  cpc_top_s st;
  cpc_top_s next_st;

  logic [PWR_W-1:0] budget;
  logic             lim_active;
  logic             over_budget;
  logic             beyond_min_duty;
  logic             pwm_on;

  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  cpc_tmr_if t_ovq ();
  cpc_tmr_if t_ovr ();
  cpc_tmr_if t_blank ();
  cpc_tmr_if t_per ();
  cpc_tmr_if t_slow ();
  cpc_tmr_if t_fast ();

  assign t_ovq.run   = charger_input_overvoltage && !st.ov_fault;
  assign t_ovr.run   = st.ov_fault && !charger_input_overvoltage;
  assign t_blank.run = st.blanking && !charge_start;
  assign t_per.run   = lim_active;
  assign t_slow.run  = st.acc_on && accessory_over_slow;
  assign t_fast.run  = st.acc_on && accessory_over_fast;

  cpc_timer #(.LIMIT(OV_QUAL_CYC))     u_ovq   (.clk(clk), .rst(rst), .t(t_ovq));
  cpc_timer #(.LIMIT(OV_RESUME_CYC))   u_ovr   (.clk(clk), .rst(rst), .t(t_ovr));
  cpc_timer #(.LIMIT(BLANK_CYC))       u_blank (.clk(clk), .rst(rst), .t(t_blank));
  cpc_timer #(.LIMIT(CTRL_PERIOD_CYC)) u_per   (.clk(clk), .rst(rst), .t(t_per));
  cpc_timer #(.LIMIT(SLOW_SHORT_CYC))  u_slow  (.clk(clk), .rst(rst), .t(t_slow));
  cpc_timer #(.LIMIT(FAST_SHORT_CYC))  u_fast  (.clk(clk), .rst(rst), .t(t_fast));

  // ---------------------------------------------------------------
  // limiter decode
  // ---------------------------------------------------------------
  assign budget          = budget_mw(power_budget_select);
  assign over_budget     = pass_power_mw > budget;
  // required duty under 10 percent when power exceeds ten budgets
  assign beyond_min_duty = 18'(pass_power_mw) > 18'(budget) * 18'(MIN_DUTY_DIV);
  assign lim_active      = !power_limiter_disable && !serial_factory_mode
                           && !reverse_supply_enable && !st.blanking;
  assign pwm_on          = st.phase < st.duty;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;

    // over-voltage fault, short pulses filtered by qualification
    if (t_ovq.done) begin
      next_st.ov_fault = 1'b1;
    end else if (t_ovr.done) begin
      next_st.ov_fault = 1'b0;
    end

    // blanking starts with each charge cycle
    if (charge_start) begin
      next_st.blanking  = 1'b1;
      next_st.pwr_fault = 1'b0;
    end else if (t_blank.done) begin
      next_st.blanking  = 1'b0;
    end

    // duty control and dissipation fault
    next_st.phase = (st.phase == DUTY_FULL - 4'h1) ? 4'h0 : st.phase + 4'h1;
    if (!lim_active || charge_start) begin
      next_st.duty = DUTY_FULL;
    end else if (t_per.done) begin
      if (over_budget && st.duty > DUTY_MIN) begin
        next_st.duty = st.duty - 4'h1;
      end else if (!over_budget && st.duty < DUTY_FULL) begin
        next_st.duty = st.duty + 4'h1;
      end
    end
    if (charge_enable && beyond_min_duty && (lim_active || st.blanking) && !charge_start) begin
      next_st.pwr_fault = 1'b1;
    end

    next_st.fault_code = (next_st.ov_fault || next_st.pwr_fault) ? FAULT_SUPPLY : FAULT_NONE;
    next_st.chg_irq    = !charger_fault_irq_mask
                         && ((next_st.ov_fault && !st.ov_fault) || (next_st.pwr_fault && !st.pwr_fault));

    // usb supply
    next_st.usb_disc = usb_overvoltage_comp;
    next_st.usb_irq  = usb_overvoltage_comp && !st.usb_disc;

    // reverse supply
    if (!reverse_supply_enable) begin
      next_st.short_trip = 1'b0;
      next_st.rev_trip   = 1'b0;
    end else begin
      if (t_slow.done || t_fast.done) begin
        next_st.short_trip = 1'b1;
      end
      if (st.acc_on && charge_current_detect) begin
        next_st.rev_trip = 1'b1;
      end
    end
    next_st.acc_on    = reverse_supply_enable && !next_st.short_trip && !next_st.rev_trip;
    next_st.short_irq = next_st.short_trip && !st.short_trip;
    next_st.rev_irq   = next_st.rev_trip && !st.rev_trip;

    // pass devices and battery switch
    next_st.pass_on = charge_enable && !next_st.ov_fault && !next_st.pwr_fault
                      && !charger_input_overvoltage && !reverse_supply_enable
                      && (!lim_active || pwm_on);
    next_st.bat_sw  = sm_battery_switch || next_st.ov_fault
                      || (lim_active && st.duty < DUTY_FULL);
    next_st.applied_current = (next_st.ov_fault || next_st.pwr_fault) ? 4'h0 : programmed_current;

    // trickle source
    next_st.trickle_on = charge_mode_select ? trickle_source_enable : sm_trickle_request;
    next_st.trickle_80 = battery_min_comparator && !battery_turnon_comparator;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= TOP_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs; over-voltage gating is immediate
  // ---------------------------------------------------------------
  assign main_pass_on        = st.pass_on && !charger_input_overvoltage;
  assign battery_switch      = st.bat_sw || charger_input_overvoltage;
  assign applied_current     = st.applied_current;
  assign charger_fault_code  = st.fault_code;
  assign charger_fault_irq   = st.chg_irq;
  assign usb_disconnect      = st.usb_disc;
  assign usb_overvoltage_irq = st.usb_irq;
  assign accessory_path_on   = st.acc_on;
  assign accessory_short_irq = st.short_irq;
  assign reverse_current_irq = st.rev_irq;
  assign trickle_source_on   = st.trickle_on;
  assign trickle_level_80ma  = st.trickle_80;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_ovp_cuts_pass: assert property (@(posedge clk) disable iff (rst)
    charger_input_overvoltage |-> !main_pass_on && battery_switch) else $error("pass not cut on over-voltage");

  a_ov_resume_wait: assert property (@(posedge clk) disable iff (rst)
    $fell(st.ov_fault) |-> $past(t_ovr.done)) else $error("over-voltage fault left without debounce");

  a_ov_restore: assert property (@(posedge clk) disable iff (rst)
    $fell(st.ov_fault) && !st.pwr_fault |-> applied_current == $past(programmed_current))
    else $error("settings not restored after resume");

  a_fault_code_set: assert property (@(posedge clk) disable iff (rst)
    (st.ov_fault || st.pwr_fault) |-> charger_fault_code == FAULT_SUPPLY && applied_current == 4'h0)
    else $error("fault code wrong during fault");

  a_fault_irq_pulse: assert property (@(posedge clk) disable iff (rst)
    $rose(st.ov_fault) && !$past(charger_fault_irq_mask) |-> charger_fault_irq)
    else $error("charger fault interrupt missing");

  a_irq_masked: assert property (@(posedge clk) disable iff (rst)
    charger_fault_irq |-> !$past(charger_fault_irq_mask)) else $error("masked interrupt raised");

  a_usb_ov_disc: assert property (@(posedge clk) disable iff (rst)
    $rose(usb_overvoltage_comp) |=> usb_disconnect && usb_overvoltage_irq ##1 !usb_overvoltage_irq)
    else $error("usb over-voltage not handled");

  a_min_duty_fault: assert property (@(posedge clk) disable iff (rst)
    charge_enable && lim_active && beyond_min_duty && !charge_start |=> st.pwr_fault && !main_pass_on)
    else $error("path not disabled beyond minimum duty");

  a_limiter_off: assert property (@(posedge clk) disable iff (rst)
    (serial_factory_mode || reverse_supply_enable || power_limiter_disable) |=> st.duty == DUTY_FULL)
    else $error("limiter active while disabled");

  a_blank_start: assert property (@(posedge clk) disable iff (rst)
    charge_start |=> st.blanking && st.duty == DUTY_FULL) else $error("blanking not started");

  a_short_trip: assert property (@(posedge clk) disable iff (rst)
    reverse_supply_enable && (t_fast.done || t_slow.done) |=> !accessory_path_on && accessory_short_irq)
    else $error("accessory short not tripped");

  a_rev_trip: assert property (@(posedge clk) disable iff (rst)
    reverse_supply_enable && accessory_path_on && charge_current_detect |=> !accessory_path_on ##0 reverse_current_irq)
    else $error("reverse current not tripped");

  a_trickle_level: assert property (@(posedge clk) disable iff (rst)
    !battery_min_comparator |=> !trickle_level_80ma) else $error("trickle level wrong below minimum");

  a_trickle_mode: assert property (@(posedge clk) disable iff (rst)
    charge_mode_select |=> trickle_source_on == $past(trickle_source_enable)) else $error("trickle enable ignored");

  c_ov_fault:  cover property (@(posedge clk) disable iff (rst) $rose(st.ov_fault));
  c_ov_resume: cover property (@(posedge clk) disable iff (rst) $fell(st.ov_fault));
  c_duty_cut:  cover property (@(posedge clk) disable iff (rst) st.duty < DUTY_FULL);
  c_short:     cover property (@(posedge clk) disable iff (rst) accessory_short_irq);

endmodule
`default_nettype wire
